// File: rtl/jnp_defs.svh
// constants for the test-port programming registers
`ifndef JNP_DEFS_SVH
`define JNP_DEFS_SVH

`define JNP_CMD_W        15
`define JNP_KEY_W        16
`define JNP_OP_W         7
`define JNP_BYTE_W       8
`define JNP_TOUT_W       12

`define JNP_PROG_KEY     16'hA370
`define JNP_KEY_RST      16'h0000
`define JNP_CMD_RST      15'h0000

`define JNP_OP_MSB       14
`define JNP_OP_LSB       8
`define JNP_STATUS_BIT   9

`define JNP_OP_ENTER     7'h23
`define JNP_OP_ADDR_EXT  7'h0B
`define JNP_OP_ADDR_HI   7'h07
`define JNP_OP_ADDR_LO   7'h03
`define JNP_OP_DATA_LO   7'h13
`define JNP_OP_DATA_HI   7'h17
`define JNP_OP_LATCH     7'h77
`define JNP_OP_IDLE_HI   7'h37
`define JNP_OP_IDLE_LO   7'h33
`define JNP_OP_WR_HI     7'h35
`define JNP_OP_WR_LO     7'h31
`define JNP_OP_RD_START  7'h32
`define JNP_OP_RD_LO     7'h36

`define JNP_ENT_ERASE    8'h80
`define JNP_ENT_FL_WR    8'h10
`define JNP_ENT_FL_RD    8'h02
`define JNP_ENT_EE_WR    8'h11

`define JNP_CLK_NS       25
`define JNP_TOUT0_NS     1000
`define JNP_TOUT1_NS     10000
`define JNP_TOUT2_NS     50000
`define JNP_TOUT3_NS     100000
`define JNP_TOUT0_CYC    ((`JNP_TOUT0_NS + `JNP_CLK_NS - 1) / `JNP_CLK_NS)
`define JNP_TOUT1_CYC    ((`JNP_TOUT1_NS + `JNP_CLK_NS - 1) / `JNP_CLK_NS)
`define JNP_TOUT2_CYC    ((`JNP_TOUT2_NS + `JNP_CLK_NS - 1) / `JNP_CLK_NS)
`define JNP_TOUT3_CYC    ((`JNP_TOUT3_NS + `JNP_CLK_NS - 1) / `JNP_CLK_NS)

`endif

// File: rtl/jnp_pkg.sv
// types for the test-port programming registers
package jnp_pkg;

	typedef enum logic [2:0]
	{
		JNP_MODE_IDLE,
		JNP_MODE_ERASE,
		JNP_MODE_FL_WR,
		JNP_MODE_FL_RD,
		JNP_MODE_EE_WR
	} jnp_mode_t;

endpackage : jnp_pkg

// File: rtl/jnp_prog.sv
// test-port reset, enable and command registers with the command engine
`timescale 1ns/1ps
`default_nettype none
`include "jnp_defs.svh"

module jnp_prog
(
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic [1:0]                 clk_opt,
	output logic                            core_rst_n,
	output logic                            prog_mode,
	input  wire logic                       tck,
	input  wire logic                       tap_tdi,
	input  wire logic                       tap_sel_reset,
	input  wire logic                       tap_sel_enable,
	input  wire logic                       tap_sel_command,
	input  wire logic                       tap_capture_dr,
	input  wire logic                       tap_shift_dr,
	input  wire logic                       tap_update_dr,
	output logic                            tap_tdo,
	output logic                            nvm_erase,
	output logic                            nvm_flash_write,
	output logic                            nvm_ee_write,
	output logic                            nvm_latch,
	output logic                            nvm_read,
	output logic                            nvm_is_ee,
	output logic [23:0]                     nvm_addr,
	output logic [15:0]                     nvm_wdata,
	input  wire logic [15:0]                nvm_rdata,
	input  wire logic                       nvm_busy
);

	function automatic logic [`JNP_TOUT_W-1:0] tout_cycles(input logic [1:0] opt);
		logic [`JNP_TOUT_W-1:0] c;
		c = `JNP_TOUT_W'(`JNP_TOUT0_CYC);
		case (opt)
			2'h1:    c = `JNP_TOUT_W'(`JNP_TOUT1_CYC);
			2'h2:    c = `JNP_TOUT_W'(`JNP_TOUT2_CYC);
			2'h3:    c = `JNP_TOUT_W'(`JNP_TOUT3_CYC);
			default: c = `JNP_TOUT_W'(`JNP_TOUT0_CYC);
		endcase
		return c;
	endfunction : tout_cycles

	function automatic logic [`JNP_CMD_W-1:0] shift_in(input logic [`JNP_CMD_W-1:0] v, input logic b);
		return {b, v[`JNP_CMD_W-1:1]};
	endfunction : shift_in

	// link domain: reset, enable and command registers on the test clock

	logic                    tck_rst_n;
	logic                    rst_bit_q;
	logic [`JNP_KEY_W-1:0]   key_sr_q;
	logic [`JNP_KEY_W-1:0]   key_q;
	logic [`JNP_CMD_W-1:0]   cmd_sr_q;
	logic [`JNP_CMD_W-1:0]   cmd_word_q;
	logic [`JNP_CMD_W-1:0]   res_tck_q;
	logic [`JNP_CMD_W-1:0]   res_sys_q;
	logic                    req_tgl_q;
	logic                    ack_tck_s;
	logic                    ack_seen_q;
	logic                    key_match;
	logic                    do_rst_shift;
	logic                    do_key_shift;
	logic                    do_key_update;
	logic                    do_cmd_capture;
	logic                    do_cmd_shift;
	logic                    do_cmd_update;
	logic                    ack_new;

	// power-on reset reaches the test clock through its own synchroniser
	jnp_sync u_tck_rst
	(
		.clk (tck),
		.d   (rst_n),
		.q   (tck_rst_n)
	);

	assign do_rst_shift   = tap_sel_reset & tap_shift_dr;
	assign do_key_shift   = tap_sel_enable & tap_shift_dr;
	assign do_key_update  = tap_sel_enable & tap_update_dr;
	assign do_cmd_capture = tap_sel_command & tap_capture_dr;
	assign do_cmd_shift   = tap_sel_command & tap_shift_dr;
	assign do_cmd_update  = tap_sel_command & tap_update_dr;
	assign key_match      = (key_q == `JNP_PROG_KEY);
	assign ack_new        = (ack_tck_s != ack_seen_q);

	// the shifting bit itself is the reset source, so reset follows tdi during the shift, with no update, via the sys_clk synchroniser
	always_ff @(posedge tck)
	begin
		if (!tck_rst_n)
			rst_bit_q <= 1'b0;
		else if (do_rst_shift)
			rst_bit_q <= tap_tdi;
	end

	always_ff @(posedge tck)
	begin
		if (!tck_rst_n)
		begin
			key_sr_q <= `JNP_KEY_RST;
			key_q    <= `JNP_KEY_RST;
		end
		else
		begin
			if (do_key_shift)
				key_sr_q <= {tap_tdi, key_sr_q[`JNP_KEY_W-1:1]};
			if (do_key_update)
				key_q <= key_sr_q;
		end
	end

	always_ff @(posedge tck)
	begin
		if (!tck_rst_n)
			cmd_sr_q <= `JNP_CMD_RST;
		else if (do_cmd_capture)
			cmd_sr_q <= res_tck_q;
		else if (do_cmd_shift)
			cmd_sr_q <= shift_in(cmd_sr_q, tap_tdi);
	end

	// word is held steady from update until the next update, long after the core took it
	always_ff @(posedge tck)
	begin
		if (!tck_rst_n)
		begin
			cmd_word_q <= `JNP_CMD_RST;
			req_tgl_q  <= 1'b0;
		end
		else if (do_cmd_update)
		begin
			cmd_word_q <= cmd_sr_q;
			req_tgl_q  <= ~req_tgl_q;
		end
	end

	always_ff @(posedge tck)
	begin
		if (!tck_rst_n)
		begin
			res_tck_q  <= `JNP_CMD_RST;
			ack_seen_q <= 1'b0;
		end
		else if (ack_new)
		begin
			res_tck_q  <= res_sys_q;
			ack_seen_q <= ack_tck_s;
		end
	end

	assign tap_tdo = tap_sel_reset   ? rst_bit_q :
	                 tap_sel_enable  ? key_sr_q[0] :
	                 tap_sel_command ? cmd_sr_q[0] : 1'b0;

	// system domain: core reset, mode and the command engine

	logic                    rst_req_s;
	logic                    en_s;
	logic                    req_s;
	logic                    req_seen_q;
	logic                    proc_q;
	logic                    ack_q;
	logic [`JNP_CMD_W-1:0]   cmd_sys_q;
	logic [`JNP_TOUT_W-1:0]  tout_q;
	logic                    core_rst_n_q;
	jnp_pkg::jnp_mode_t      mode_q;
	jnp_pkg::jnp_mode_t      mode_d;
	logic [7:0]              addr_ext_q;
	logic [7:0]              addr_hi_q;
	logic [7:0]              addr_lo_q;
	logic [7:0]              data_lo_q;
	logic [7:0]              data_hi_q;
	logic                    erase_q;
	logic                    fl_wr_q;
	logic                    ee_wr_q;
	logic                    latch_q;
	logic                    read_q;

	jnp_sync u_rst_req
	(
		.clk (sys_clk),
		.d   (rst_bit_q),
		.q   (rst_req_s)
	);

	jnp_sync u_en
	(
		.clk (sys_clk),
		.d   (key_match),
		.q   (en_s)
	);

	jnp_sync u_req
	(
		.clk (sys_clk),
		.d   (req_tgl_q),
		.q   (req_s)
	);

	jnp_sync u_ack
	(
		.clk (tck),
		.d   (ack_q),
		.q   (ack_tck_s)
	);

	// time-out reloads for as long as the request stands, then counts down
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			tout_q       <= `JNP_TOUT_W'(0);
			core_rst_n_q <= 1'b0;
		end
		else if (rst_req_s)
		begin
			tout_q       <= tout_cycles(clk_opt);
			core_rst_n_q <= 1'b0;
		end
		else if (tout_q != `JNP_TOUT_W'(0))
		begin
			tout_q       <= tout_q - `JNP_TOUT_W'(1);
			core_rst_n_q <= 1'b0;
		end
		else
			core_rst_n_q <= 1'b1;
	end

	// the immediate request also gates the output so reset does not wait for the register
	assign core_rst_n = core_rst_n_q & ~rst_req_s;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			req_seen_q <= 1'b0;
			proc_q     <= 1'b0;
			cmd_sys_q  <= `JNP_CMD_RST;
		end
		else
		begin
			req_seen_q <= req_s;
			proc_q     <= (req_s != req_seen_q);
			if (req_s != req_seen_q)
				cmd_sys_q <= cmd_word_q;
		end
	end

	logic [`JNP_OP_W-1:0]    opcode;
	logic [`JNP_BYTE_W-1:0]  operand;
	logic                    act;
	logic                    is_enter;
	logic                    hit_erase;
	logic                    hit_fl_wr;
	logic                    hit_ee_wr;
	logic                    hit_latch;
	logic                    hit_read;
	logic                    ret_lo;
	logic                    ret_hi;
	logic [`JNP_BYTE_W-1:0]  ret_byte;
	logic [`JNP_CMD_W-1:0]   res_d;

	assign opcode    = cmd_sys_q[`JNP_OP_MSB:`JNP_OP_LSB];
	assign operand   = cmd_sys_q[`JNP_OP_LSB-1:0];
	assign act       = proc_q & en_s;
	assign is_enter  = act & (opcode == `JNP_OP_ENTER);
	assign hit_erase = act & (opcode == `JNP_OP_WR_LO) & (mode_q == jnp_pkg::JNP_MODE_ERASE);
	assign hit_fl_wr = act & (opcode == `JNP_OP_WR_HI) & (mode_q == jnp_pkg::JNP_MODE_FL_WR);
	assign hit_ee_wr = act & (opcode == `JNP_OP_WR_LO) & (mode_q == jnp_pkg::JNP_MODE_EE_WR);
	assign hit_latch = act & (opcode == `JNP_OP_LATCH)
	                 & ((mode_q == jnp_pkg::JNP_MODE_FL_WR) | (mode_q == jnp_pkg::JNP_MODE_EE_WR));
	assign hit_read  = act & (opcode == `JNP_OP_RD_START) & (mode_q == jnp_pkg::JNP_MODE_FL_RD);
	// a word's result leaves on the next shift, so the start word carries the low byte
	assign ret_lo    = (opcode == `JNP_OP_RD_START) & (mode_q == jnp_pkg::JNP_MODE_FL_RD);
	assign ret_hi    = (opcode == `JNP_OP_RD_LO) & (mode_q == jnp_pkg::JNP_MODE_FL_RD);
	assign ret_byte  = ret_lo ? nvm_rdata[7:0] : ret_hi ? nvm_rdata[15:8] : `JNP_BYTE_W'(0);

	always_comb
	begin
		res_d                  = `JNP_CMD_RST;
		res_d[`JNP_BYTE_W-1:0] = ret_byte;
		res_d[`JNP_STATUS_BIT] = ~nvm_busy;
	end

	always_comb
	begin
		mode_d = mode_q;
		if (is_enter)
		begin
			case (operand)
				`JNP_ENT_ERASE: mode_d = jnp_pkg::JNP_MODE_ERASE;
				`JNP_ENT_FL_WR: mode_d = jnp_pkg::JNP_MODE_FL_WR;
				`JNP_ENT_FL_RD: mode_d = jnp_pkg::JNP_MODE_FL_RD;
				`JNP_ENT_EE_WR: mode_d = jnp_pkg::JNP_MODE_EE_WR;
				default:        mode_d = jnp_pkg::JNP_MODE_IDLE;
			endcase
		end
	end

	// dropping the key leaves programming mode at once
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n || !en_s)
			mode_q <= jnp_pkg::JNP_MODE_IDLE;
		else
			mode_q <= mode_d;
	end

	// address and data loads stand in every mode; the mode picks what a strobe does
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			addr_ext_q <= `JNP_BYTE_W'(0);
			addr_hi_q  <= `JNP_BYTE_W'(0);
			addr_lo_q  <= `JNP_BYTE_W'(0);
			data_lo_q  <= `JNP_BYTE_W'(0);
			data_hi_q  <= `JNP_BYTE_W'(0);
		end
		else if (act)
		begin
			if (opcode == `JNP_OP_ADDR_EXT)
				addr_ext_q <= operand;
			if (opcode == `JNP_OP_ADDR_HI)
				addr_hi_q <= operand;
			if (opcode == `JNP_OP_ADDR_LO)
				addr_lo_q <= operand;
			if (opcode == `JNP_OP_DATA_LO)
				data_lo_q <= operand;
			if (opcode == `JNP_OP_DATA_HI)
				data_hi_q <= operand;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			erase_q <= 1'b0;
			fl_wr_q <= 1'b0;
			ee_wr_q <= 1'b0;
			latch_q <= 1'b0;
			read_q  <= 1'b0;
		end
		else
		begin
			erase_q <= hit_erase;
			fl_wr_q <= hit_fl_wr;
			ee_wr_q <= hit_ee_wr;
			latch_q <= hit_latch;
			read_q  <= hit_read;
		end
	end

	// status is sampled when the word lands, so each poll sees the busy flag of its own moment
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			res_sys_q <= `JNP_CMD_RST;
			ack_q     <= 1'b0;
		end
		else if (proc_q)
		begin
			res_sys_q <= en_s ? res_d : `JNP_CMD_RST;
			ack_q     <= ~ack_q;
		end
	end

	assign prog_mode       = en_s;
	assign nvm_erase       = erase_q;
	assign nvm_flash_write = fl_wr_q;
	assign nvm_ee_write    = ee_wr_q;
	assign nvm_latch       = latch_q;
	assign nvm_read        = read_q;
	assign nvm_is_ee       = (mode_q == jnp_pkg::JNP_MODE_EE_WR);
	assign nvm_addr        = {addr_ext_q, addr_hi_q, addr_lo_q};
	assign nvm_wdata       = {data_hi_q, data_lo_q};

endmodule : jnp_prog

`default_nettype wire

// File: rtl/jnp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module jnp_sync
(
	input  wire logic clk,
	input  wire logic d,
	output logic      q
);

	logic meta_q;

	always_ff @(posedge clk)
	begin
		meta_q <= d;
		q      <= meta_q;
	end

endmodule : jnp_sync

`default_nettype wire

// File: tb/jnp_host_model.sv
// programmer model driving the test-port side
`timescale 1ns/1ps
`default_nettype none

module jnp_host_model
(
	output var logic tck,
	output var logic tap_tdi,
	output var logic tap_sel_reset,
	output var logic tap_sel_enable,
	output var logic tap_sel_command,
	output var logic tap_capture_dr,
	output var logic tap_shift_dr,
	output var logic tap_update_dr,
	input  wire logic tap_tdo
);
	initial
		{tck, tap_tdi, tap_sel_reset, tap_sel_enable, tap_sel_command, tap_capture_dr, tap_shift_dr, tap_update_dr} = 8'h00;

	// test clock stands still between requests
	task tick(input int n);
		repeat (n)
		begin
			#80 tck = 1'b1;
			#80 tck = 1'b0;
		end
	endtask : tick

	// sel 0 reset, 1 enable, 2 command
	task scan(input int sel, input int n, input logic [15:0] d, output logic [15:0] q);
		q = 16'h0000;
		{tap_sel_command, tap_sel_enable, tap_sel_reset} = 3'h1 << sel;
		tap_capture_dr = 1'b1;
		tick(1);
		{tap_capture_dr, tap_shift_dr} = 2'h1;
		for (int i = 0; i < n; i++)
		begin
			tap_tdi = d[i];
			q[i] = tap_tdo;
			tick(1);
		end
		{tap_shift_dr, tap_update_dr} = 2'h1;
		tap_tdi = ~tap_tdi;
		tick(1);
		{tap_update_dr, tap_sel_reset, tap_sel_enable, tap_sel_command} = 4'h0;
		// result must cross domains before the next capture
		tick(4);
	endtask : scan
endmodule : jnp_host_model

`default_nettype wire

// File: tb/jnp_prog_asserts.sv
// port assertions for the test-port programming block
`timescale 1ns/1ps
`default_nettype none

module jnp_prog_asserts
(
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic [1:0]  clk_opt,
	input wire logic        core_rst_n,
	input wire logic        prog_mode,
	input wire logic        tck,
	input wire logic        tap_sel_reset,
	input wire logic        tap_sel_enable,
	input wire logic        tap_sel_command,
	input wire logic        tap_tdo,
	input wire logic        nvm_erase,
	input wire logic        nvm_flash_write,
	input wire logic        nvm_ee_write,
	input wire logic        nvm_latch,
	input wire logic        nvm_read,
	input wire logic        nvm_is_ee,
	input wire logic [23:0] nvm_addr
);
	logic [12:0] low_q;
	logic [12:0] low_d;
	logic [12:0] tout;
	logic        pulse;

	// counts the whole low span, so it always covers the time-out
	assign low_d = core_rst_n ? 13'h0000 : low_q + 13'h0001;
	assign tout = clk_opt[1] ? (clk_opt[0] ? 13'h0FA0 : 13'h07D0) : (clk_opt[0] ? 13'h0190 : 13'h0028);
	assign pulse = nvm_erase | nvm_flash_write | nvm_ee_write | nvm_latch | nvm_read;

	always_ff @(posedge sys_clk)
		if (!rst_n)
			low_q <= 13'h0000;
		else
			low_q <= low_d;

	sequence s_fall;
		$fell(core_rst_n);
	endsequence
	sequence s_low;
		!core_rst_n [*8];
	endsequence

	chk_core_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) s_fall |=> s_low)
		else $error("core reset released too soon");
	chk_tout_min: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(core_rst_n) && low_q > 13'h0004 |-> low_q >= tout) else $error("time-out too short");
	chk_key_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) $rose(rst_n) |-> !prog_mode)
		else $error("enabled after reset");
	chk_prog_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) pulse |-> prog_mode)
		else $error("action while locked");
	chk_pulse_once: assert property (@(posedge sys_clk) disable iff (!rst_n) pulse |=> !pulse)
		else $error("action pulse too long");
	chk_ee_mode: assert property (@(posedge sys_clk) disable iff (!rst_n) nvm_ee_write |-> nvm_is_ee)
		else $error("eeprom write outside mode");
	chk_addr_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) nvm_latch |-> $stable(nvm_addr))
		else $error("address moved at latch");
	chk_tdo_idle: assert property (@(posedge tck) disable iff (!rst_n)
		!(tap_sel_reset | tap_sel_enable | tap_sel_command) |-> !tap_tdo) else $error("tdo driven unselected");
endmodule : jnp_prog_asserts

bind jnp_prog jnp_prog_asserts u_chk
(
	.sys_clk, .rst_n, .clk_opt, .core_rst_n, .prog_mode, .tck, .tap_sel_reset, .tap_sel_enable,
	.tap_sel_command, .tap_tdo, .nvm_erase, .nvm_flash_write, .nvm_ee_write, .nvm_latch, .nvm_read,
	.nvm_is_ee, .nvm_addr
);

`default_nettype wire

// File: tb/jnp_prog_tb.sv
// self-checking bench for the test-port programming block
`timescale 1ns/1ps
`default_nettype none

module jnp_prog_tb;
	logic             sys_clk;
	logic             rst_n = 1'b0;
	logic [1:0]       clk_opt = 2'h0;
	logic             nvm_busy = 1'b0;
	logic [15:0]      nvm_rdata = 16'hC35A;
	wire logic        tck, tap_tdi, tap_sel_reset, tap_sel_enable, tap_sel_command;
	wire logic        tap_capture_dr, tap_shift_dr, tap_update_dr, tap_tdo, core_rst_n, prog_mode;
	wire logic        nvm_erase, nvm_flash_write, nvm_ee_write, nvm_latch, nvm_read, nvm_is_ee;
	wire logic [23:0] nvm_addr;
	wire logic [15:0] nvm_wdata;
	wire logic [4:0]  pv;
	logic [15:0]      r;
	logic [15:0]      q;
	logic [23:0]      cap_a;
	logic [15:0]      cap_d;
	int               pc [5] = '{default: 0};
	int               low_n = 0;
	int               last_low = 0;
	int               failures = 0;
	int               check_count = 0;
	int               tt [4] = '{40, 400, 2000, 4000};

	assign pv = {nvm_read, nvm_latch, nvm_ee_write, nvm_flash_write, nvm_erase};

	jnp_prog dut
	(
		.sys_clk, .rst_n, .clk_opt, .core_rst_n, .prog_mode, .tck, .tap_tdi, .tap_sel_reset, .tap_sel_enable,
		.tap_sel_command, .tap_capture_dr, .tap_shift_dr, .tap_update_dr, .tap_tdo, .nvm_erase, .nvm_flash_write,
		.nvm_ee_write, .nvm_latch, .nvm_read, .nvm_is_ee, .nvm_addr, .nvm_wdata, .nvm_rdata, .nvm_busy
	);

	jnp_host_model host
	(
		.tck, .tap_tdi, .tap_sel_reset, .tap_sel_enable, .tap_sel_command,
		.tap_capture_dr, .tap_shift_dr, .tap_update_dr, .tap_tdo
	);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		for (int k = 0; k < 5; k++)
			pc[k] += (pv[k] === 1'b1);
		if (nvm_latch === 1'b1 || nvm_read === 1'b1)
			{cap_a, cap_d} = {nvm_addr, nvm_wdata};
		if (core_rst_n === 1'b0)
			low_n++;
		else if (low_n > 0)
		begin
			last_low = low_n;
			low_n = 0;
		end
	end

	task test_done;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task cmd(input logic [6:0] op, input logic [7:0] arg);
		host.scan(2, 15, {1'b0, op, arg}, r);
	endtask : cmd

	task wait_core;
		int k;
		k = 0;
		while (core_rst_n !== 1'b1 && k < 5000)
		begin
			@(posedge sys_clk);
			#1 k++;
		end
		if (k >= 5000)
		begin
			failures++;
			test_done;
		end
		repeat (2) @(posedge sys_clk);
	endtask : wait_core

	task poll(input logic [6:0] op, input logic [7:0] arg);
		@(posedge sys_clk) nvm_busy <= 1'b1;
		cmd(op, arg);
		@(posedge sys_clk) nvm_busy <= 1'b0;
		cmd(op, arg);
		chk("busy bit", r[9], 1'h0);
		cmd(op, arg);
		chk("done bit", r[9], 1'h1);
	endtask : poll

	// one-tck reset pulse: reset acts while shifting, then time-out
	task s_reset_reg;
		for (int o = 0; o < 4; o++)
		begin
			@(posedge sys_clk) clk_opt <= 2'(o);
			last_low = 0;
			host.scan(0, 2, 16'h0001, q);
			wait_core;
			chk("low span", last_low >= tt[o] + 4 && last_low <= tt[o] + 12, 1'h1);
		end
	endtask : s_reset_reg

	task s_enable;
		chk("mode at reset", prog_mode, 1'h0);
		cmd(7'h23, 8'h80);
		cmd(7'h31, 8'h80);
		chk("locked result", r, 16'h0000);
		host.scan(1, 16, 16'hA371, q);
		chk("bad key", prog_mode, 1'h0);
		host.scan(1, 16, 16'hA370, q);
		chk("good key", prog_mode, 1'h1);
	endtask : s_enable

	task s_erase;
		cmd(7'h23, 8'h80);
		cmd(7'h31, 8'h80);
		cmd(7'h33, 8'h80);
		cmd(7'h33, 8'h80);
		chk("erase", pc[0], 1);
		poll(7'h33, 8'h80);
	endtask : s_erase

	task s_flash_wr;
		cmd(7'h23, 8'h10);
		chk("flash mode", nvm_is_ee, 1'h0);
		cmd(7'h0B, 8'h5A);
		cmd(7'h07, 8'h3C);
		cmd(7'h03, 8'hA5);
		cmd(7'h13, 8'h12);
		cmd(7'h17, 8'h34);
		cmd(7'h37, 8'h00);
		cmd(7'h77, 8'h00);
		cmd(7'h37, 8'h00);
		chk("latch addr", cap_a, 24'h5A3CA5);
		chk("latch data", cap_d, 16'h3412);
		cmd(7'h35, 8'h00);
		cmd(7'h37, 8'h00);
		chk("page write", pc[1], 1);
		poll(7'h37, 8'h00);
	endtask : s_flash_wr

	task s_flash_rd;
		cmd(7'h23, 8'h02);
		cmd(7'h0B, 8'h01);
		cmd(7'h07, 8'h02);
		cmd(7'h03, 8'h03);
		cmd(7'h32, 8'h00);
		cmd(7'h36, 8'h00);
		chk("low byte", r[7:0], 8'h5A);
		chk("read addr", cap_a, 24'h010203);
		cmd(7'h37, 8'h00);
		chk("high byte", r[7:0], 8'hC3);
	endtask : s_flash_rd

	task s_ee_wr;
		cmd(7'h23, 8'h11);
		chk("ee mode", nvm_is_ee, 1'h1);
		cmd(7'h07, 8'h0F);
		cmd(7'h03, 8'hF0);
		cmd(7'h13, 8'h99);
		cmd(7'h37, 8'h00);
		cmd(7'h77, 8'h00);
		cmd(7'h37, 8'h00);
		chk("ee latch", {cap_a[15:0], cap_d[7:0]}, 24'h0FF099);
		cmd(7'h33, 8'h00);
		cmd(7'h31, 8'h00);
		cmd(7'h33, 8'h00);
		cmd(7'h33, 8'h00);
		chk("ee write", pc[2], 1);
		poll(7'h33, 8'h00);
	endtask : s_ee_wr

	task s_key_clear;
		host.scan(1, 16, 16'h0000, q);
		chk("mode cleared", prog_mode, 1'h0);
		cmd(7'h23, 8'h80);
		cmd(7'h31, 8'h80);
		cmd(7'h33, 8'h80);
		chk("cleared result", r, 16'h0000);
		chk("no erase", pc[0], 1);
	endtask : s_key_clear

	initial
	begin
		#7 host.tick(6);
		@(posedge sys_clk) rst_n <= 1'b1;
		host.tick(3);
		s_reset_reg;
		s_enable;
		s_erase;
		s_flash_wr;
		s_flash_rd;
		s_ee_wr;
		s_key_clear;
		test_done;
	end
endmodule : jnp_prog_tb

`default_nettype wire
